/* xoc_crystal_ctrl.sv */
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module xoc_crystal_ctrl (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [xoc_pkg::ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [xoc_pkg::ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Crystal side
    input wire logic xtal_tick,
    output logic osc_run,
    output logic osc_settled
);
    typedef struct packed {
        logic aw_full;
        logic [xoc_pkg::ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [11:0] ena_code;
        logic [11:0] band_code;
        logic [31:0] pause_word;
        logic [13:0] delay;
        logic quad;
        logic illegal;
        logic [7:0] count;
        logic run;
        logic settled;
    } xoc_state_t;

    xoc_state_t q;
    xoc_state_t n;
    logic [31:0] wmask;

    xoc_settle_if settle ();

    xoc_settle_timer u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .sif(settle.timer)
    );

    assign settle.run = q.run;
    assign settle.delay = q.delay;
    assign settle.quad = q.quad;
    assign settle.tick = xtal_tick;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_lane
            assign wmask[8*gi +: 8] = {8{q.w_strb[gi]}};
        end
    endgenerate

    function automatic logic [4:0] word_addr(
        input logic [xoc_pkg::ADDR_W-1:0] a
    );
        word_addr = {a[4:2], 2'h0};
    endfunction

    function automatic logic addr_hit(input logic [4:0] a);
        logic [4:0] w;
        w = word_addr(a);
        if (w == xoc_pkg::OFF_CTRL)
        begin
            addr_hit = 1'b1;
        end
        else if (w == xoc_pkg::OFF_STATUS)
        begin
            addr_hit = 1'b1;
        end
        else if (w == xoc_pkg::OFF_PAUSE)
        begin
            addr_hit = 1'b1;
        end
        else if (w == xoc_pkg::OFF_STARTUP)
        begin
            addr_hit = 1'b1;
        end
        else if (w == xoc_pkg::OFF_COUNT)
        begin
            addr_hit = 1'b1;
        end
        else
        begin
            addr_hit = 1'b0;
        end
    endfunction

    // A stray code still lands in its field, but it is flagged so that
    // software can tell a corrupted write from an intended one.
    function automatic logic ena_bad(input logic [11:0] c);
        if (c == xoc_pkg::ENA_OFF_CODE)
        begin
            ena_bad = 1'b0;
        end
        else if (c == xoc_pkg::ENA_ON_CODE)
        begin
            ena_bad = 1'b0;
        end
        else
        begin
            ena_bad = 1'b1;
        end
    endfunction

    function automatic logic band_bad(input logic [11:0] c);
        if (c < xoc_pkg::BAND_1_15)
        begin
            band_bad = 1'b1;
        end
        else if (c > xoc_pkg::BAND_RSV_MAX)
        begin
            band_bad = 1'b1;
        end
        else
        begin
            band_bad = 1'b0;
        end
    endfunction

    // Reserved positions are built as zero here, which also makes
    // partial-strobe merges leave them at zero.
    function automatic logic [31:0] rd_word(
        input xoc_state_t s,
        input logic [4:0] a
    );
        logic [4:0] w;
        w = word_addr(a);
        rd_word = 32'h00000000;
        if (w == xoc_pkg::OFF_CTRL)
        begin
            rd_word[xoc_pkg::CTRL_ENA_LSB +: 12] = s.ena_code;
            rd_word[xoc_pkg::CTRL_BAND_LSB +: 12] = s.band_code;
        end
        else if (w == xoc_pkg::OFF_STATUS)
        begin
            rd_word[xoc_pkg::ST_SETTLED_BIT] = s.settled;
            rd_word[xoc_pkg::ST_ILLEGAL_BIT] = s.illegal;
            rd_word[xoc_pkg::ST_ENABLED_BIT] =
                (s.ena_code != xoc_pkg::ENA_OFF_CODE);
            rd_word[1:0] = xoc_pkg::ST_BAND_VAL;
        end
        else if (w == xoc_pkg::OFF_PAUSE)
        begin
            rd_word = s.pause_word;
        end
        else if (w == xoc_pkg::OFF_STARTUP)
        begin
            rd_word[xoc_pkg::SU_DELAY_W-1:0] = s.delay;
            rd_word[xoc_pkg::SU_QUAD_BIT] = s.quad;
        end
        else if (w == xoc_pkg::OFF_COUNT)
        begin
            rd_word[7:0] = s.count;
        end
    endfunction

    always_comb
    begin
        logic [31:0] cur;
        logic [31:0] wv;
        logic [4:0] wa;
        logic [11:0] ena;
        logic [11:0] band;
        logic illegal_set;
        logic illegal_clr;
        logic count_wr;
        cur = 32'h00000000;
        wv = 32'h00000000;
        wa = word_addr(q.aw_addr);
        ena = 12'h000;
        band = 12'h000;
        illegal_set = 1'b0;
        illegal_clr = 1'b0;
        count_wr = 1'b0;
        n = q;

        // Address and data are taken independently, in either order.
        if (s_axi_awvalid && q.awready)
        begin
            n.aw_full = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready)
        begin
            n.w_full = 1'b1;
            n.w_data = s_axi_wdata;
            n.w_strb = s_axi_wstrb;
        end

        if (q.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
        end

        // Unwritten byte lanes keep their current contents.
        if (q.aw_full && q.w_full && !q.bvalid)
        begin
            cur = rd_word(q, q.aw_addr);
            wv = (cur & ~wmask) | (q.w_data & wmask);
            n.aw_full = 1'b0;
            n.w_full = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = xoc_pkg::RESP_OKAY;
            if (wa == xoc_pkg::OFF_CTRL)
            begin
                ena = wv[xoc_pkg::CTRL_ENA_LSB +: 12];
                band = wv[xoc_pkg::CTRL_BAND_LSB +: 12];
                if (ena_bad(ena))
                begin
                    illegal_set = 1'b1;
                end
                n.ena_code = ena;
                if (band_bad(band))
                begin
                    illegal_set = 1'b1;
                end
                n.band_code = band;
            end
            else if (wa == xoc_pkg::OFF_STATUS)
            begin
                illegal_clr = q.w_strb[3] &&
                    q.w_data[xoc_pkg::ST_ILLEGAL_BIT];
            end
            else if (wa == xoc_pkg::OFF_PAUSE)
            begin
                if (wv == xoc_pkg::PAUSE_CODE)
                begin
                    n.pause_word = xoc_pkg::PAUSE_CODE;
                end
                else
                begin
                    n.pause_word = xoc_pkg::RUN_CODE;
                    if (wv != xoc_pkg::RUN_CODE)
                    begin
                        illegal_set = 1'b1;
                    end
                end
            end
            else if (wa == xoc_pkg::OFF_STARTUP)
            begin
                n.delay = wv[xoc_pkg::SU_DELAY_W-1:0];
                n.quad = wv[xoc_pkg::SU_QUAD_BIT];
            end
            else if (wa == xoc_pkg::OFF_COUNT)
            begin
                n.count = wv[7:0];
                count_wr = 1'b1;
            end
            else
            begin
                n.bresp = xoc_pkg::RESP_SLVERR;
            end
        end

        if (q.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready)
        begin
            n.rvalid = 1'b1;
            n.rdata = rd_word(q, s_axi_araddr);
            n.rresp = addr_hit(s_axi_araddr) ? xoc_pkg::RESP_OKAY :
                xoc_pkg::RESP_SLVERR;
        end

        // A fresh illegal write wins over a clear in the same cycle.
        n.illegal = (q.illegal && !illegal_clr) || illegal_set;

        // Ticks are only counted while the oscillator runs, so the count freezes
        // when the oscillator is off or paused.
        if (!count_wr && q.run && xtal_tick && (q.count != 8'h00))
        begin
            n.count = q.count - 8'h01;
        end

        // Any code other than the off code turns the oscillator on.
        n.run = (q.ena_code != xoc_pkg::ENA_OFF_CODE) &&
            (q.pause_word != xoc_pkg::PAUSE_CODE);
        n.settled = settle.stable && q.run;

        n.awready = !n.aw_full && !n.bvalid;
        n.wready = !n.w_full && !n.bvalid;
        n.arready = !n.rvalid;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            q <= '0;
            q.ena_code <= xoc_pkg::ENA_OFF_CODE;
            q.band_code <= xoc_pkg::BAND_1_15;
            q.pause_word <= xoc_pkg::RUN_CODE;
            q.delay <= xoc_pkg::SU_DELAY_RST;
            q.quad <= xoc_pkg::SU_QUAD_RST;
            q.count <= xoc_pkg::COUNT_RST;
        end
        else
        begin
            q <= n;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign osc_run = q.run;
    assign osc_settled = q.settled;
endmodule

/* xoc_pkg.sv */
// Overview of operation
// - Status bit 31 shows oscillator running and stable.
// - Bad control or pause codes set bit 24.
// - Status bit 12 shows oscillator turned on.
// - Status band field always reads zero.
// - Pause code stops oscillator, run code runs.
// - Pause register resets to the run code.
// - Other pause words act as run code.
// - Start-up delay is 14 bits, unit 256.
// - Quadruple bit multiplies start-up delay by four.
// - Eight-bit crystal down counter stops at zero.
// - Writing nonzero value starts the down counter while the oscillator runs.
// - On/off field: off code, on code, else on.
// - Band field reads back the written code, never changes use.
package xoc_pkg;
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_STATUS = 5'h04;
    localparam logic [4:0] OFF_PAUSE = 5'h08;
    localparam logic [4:0] OFF_STARTUP = 5'h0C;
    localparam logic [4:0] OFF_COUNT = 5'h1C;
    localparam logic [11:0] ENA_OFF_CODE = 12'hD1E;
    localparam logic [11:0] ENA_ON_CODE = 12'hFAB;
    localparam logic [11:0] BAND_1_15 = 12'hAA0;
    localparam logic [11:0] BAND_RSV_MAX = 12'hAA3;
    localparam int CTRL_ENA_LSB = 12;
    localparam int CTRL_BAND_LSB = 0;
    localparam logic [31:0] PAUSE_CODE = 32'h636F6D61;
    localparam logic [31:0] RUN_CODE = 32'h77616B65;
    localparam int ST_SETTLED_BIT = 31;
    localparam int ST_ILLEGAL_BIT = 24;
    localparam int ST_ENABLED_BIT = 12;
    localparam logic [1:0] ST_BAND_VAL = 2'h0;
    localparam int SU_QUAD_BIT = 20;
    localparam int SU_DELAY_W = 14;
    localparam logic [13:0] SU_DELAY_RST = 14'h00C4;
    localparam logic SU_QUAD_RST = 1'b0;
    localparam int SU_UNIT_SHIFT = 8;
    localparam int SU_QUAD_SHIFT = 2;
    localparam int SETTLE_W = 24;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* xoc_settle_if.sv */
`timescale 1ns/10ps
interface xoc_settle_if;
    logic run;
    logic [xoc_pkg::SU_DELAY_W-1:0] delay;
    logic quad;
    logic tick;
    logic stable;
    modport ctrl (output run, output delay, output quad, output tick,
        input stable);
    modport timer (input run, input delay, input quad, input tick,
        output stable);
endinterface

/* xoc_settle_timer.sv */
`timescale 1ns/10ps
module xoc_settle_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Link to the register block
    xoc_settle_if.timer sif
);
    typedef struct packed {
        logic [xoc_pkg::SETTLE_W-1:0] cnt;
        logic busy;
        logic stable;
    } xoc_tmr_t;

    xoc_tmr_t q;
    xoc_tmr_t n;
    logic [xoc_pkg::SETTLE_W-1:0] base;
    logic [xoc_pkg::SETTLE_W-1:0] total;

    // The delay is sampled once at start-up, so a later rewrite of the
    // delay only affects the next start.
    always_comb
    begin
        base = {{(xoc_pkg::SETTLE_W - xoc_pkg::SU_DELAY_W){1'b0}},
            sif.delay} << xoc_pkg::SU_UNIT_SHIFT;
        total = sif.quad ? (base << xoc_pkg::SU_QUAD_SHIFT) : base;
        n = q;
        if (!sif.run)
        begin
            n.cnt = '0;
            n.busy = 1'b0;
            n.stable = 1'b0;
        end
        else if (!q.busy && !q.stable)
        begin
            n.cnt = total;
            n.busy = 1'b1;
        end
        else if (q.busy)
        begin
            if (q.cnt == '0)
            begin
                n.busy = 1'b0;
                n.stable = 1'b1;
            end
            else if (sif.tick)
            begin
                n.cnt = q.cnt - 24'h000001;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

    assign sif.stable = q.stable;
endmodule

/* xoc_crystal_ctrl_assertions.sv */
`timescale 1ns/10ps
module xoc_crystal_ctrl_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // Crystal side
    input wire logic xtal_tick,
    input wire logic osc_run,
    input wire logic osc_settled
);
    logic [4:0] wa_q;
    logic [31:0] wd_q;
    logic [4:0] ra_q;
    logic wmap;
    logic rmap;
    // Fields are caught at their own handshakes, as AW and W may be
    // taken on different edges.
    always_ff @(posedge clk_sys)
    begin
        if (s_axi_awvalid && s_axi_awready)
            wa_q <= {s_axi_awaddr[4:2], 2'h0};
        if (s_axi_wvalid && s_axi_wready)
            wd_q <= s_axi_wdata;
        if (s_axi_arvalid && s_axi_arready)
            ra_q <= {s_axi_araddr[4:2], 2'h0};
    end
    assign wmap = wa_q inside {5'h00, 5'h04, 5'h08, 5'h0C, 5'h1C};
    assign rmap = ra_q inside {5'h00, 5'h04, 5'h08, 5'h0C, 5'h1C};
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    property p_settle_drop;
        !osc_run [*3] |-> !osc_settled;
    endproperty
    a_settle_drop: assert property (p_settle_drop)
        else $error("settled held while stopped");
    property p_settle_late;
        $rose(osc_run) |-> !osc_settled [*2];
    endproperty
    a_settle_late: assert property (p_settle_late)
        else $error("settled too early after start");
    property p_settle_rise;
        $rose(osc_settled) |-> osc_run && $past(osc_run, 2);
    endproperty
    a_settle_rise: assert property (p_settle_rise)
        else $error("settled rose without running");
    property p_stat_rsv;
        s_axi_rvalid && ra_q == 5'h04 |-> s_axi_rdata[30:25] == 6'h00
            && s_axi_rdata[23:13] == 11'h000 && s_axi_rdata[11:0] == 12'h000;
    endproperty
    a_stat_rsv: assert property (p_stat_rsv)
        else $error("status zero bits not zero");
    property p_su_rsv;
        s_axi_rvalid && ra_q == 5'h0C |->
            {s_axi_rdata[31:21], s_axi_rdata[19:14]} == 17'h0;
    endproperty
    a_su_rsv: assert property (p_su_rsv)
        else $error("startup spare bits not zero");
    property p_cnt_rsv;
        s_axi_rvalid && ra_q == 5'h1C |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_cnt_rsv: assert property (p_cnt_rsv)
        else $error("counter wider than eight bits");
    property p_pause;
        $rose(s_axi_bvalid) && wa_q == 5'h08 && wd_q == xoc_pkg::PAUSE_CODE
            |-> ##[1:2] !osc_run;
    endproperty
    a_pause: assert property (p_pause)
        else $error("pause code did not stop");
    property p_off;
        $rose(s_axi_bvalid) && wa_q == 5'h00
            && wd_q[23:12] == xoc_pkg::ENA_OFF_CODE |-> ##[1:2] !osc_run;
    endproperty
    a_off: assert property (p_off)
        else $error("off code did not stop");
    property p_wresp;
        $rose(s_axi_bvalid) |-> s_axi_bresp ==
            (wmap ? xoc_pkg::RESP_OKAY : xoc_pkg::RESP_SLVERR);
    endproperty
    a_wresp: assert property (p_wresp)
        else $error("wrong write response");
    property p_rresp;
        s_axi_rvalid |-> s_axi_rresp ==
            (rmap ? xoc_pkg::RESP_OKAY : xoc_pkg::RESP_SLVERR);
    endproperty
    a_rresp: assert property (p_rresp)
        else $error("wrong read response");
endmodule
bind xoc_crystal_ctrl xoc_crystal_ctrl_chk u_chk (.*);

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic clk_sys, rst, xtal_tick, tick_en;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, osc_run, osc_settled;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
    logic [31:0] cw [3] = '{32'h00123AA0, 32'h00FABAA5, 32'h00D1EAA0};
    logic [31:0] cs [3] = '{32'h81001000, 32'h81001000, 32'h00000000};
    int bad_count = 0;
    int total_checks = 0;
    int n;
    xoc_crystal_ctrl u_dut (.*);
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Ticks come from the bench so the settle time can be counted exactly.
    always @(posedge clk_sys) xtal_tick <= tick_en;
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        br = s_axi_bresp;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        rr = s_axi_rresp;
        chk(s_axi_rdata, e);
    endtask
    task automatic wait_set;
        n = 0;
        while (osc_settled !== 1'b1)
        begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    initial
    begin
        #100000;
        bad_count++;
        complete_run();
    end
    initial
    begin
        rst = 1'b1;
        tick_en = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_awaddr = 5'h00;
        s_axi_araddr = 5'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(xoc_pkg::OFF_CTRL, 32'h00D1EAA0);
        rdc(xoc_pkg::OFF_STATUS, 32'h0);
        rdc(xoc_pkg::OFF_PAUSE, xoc_pkg::RUN_CODE);
        rdc(xoc_pkg::OFF_STARTUP, 32'h000000C4);
        rdc(xoc_pkg::OFF_COUNT, 32'h0);
        rdc(5'h10, 32'h0);
        chk({30'h0, rr}, {30'h0, xoc_pkg::RESP_SLVERR});
        wr(5'h14, 32'hFFFFFFFF);
        chk({30'h0, br}, {30'h0, xoc_pkg::RESP_SLVERR});
        $display("test reset values done");
        wr(xoc_pkg::OFF_STARTUP, 32'hFFFFFFFF);
        chk({30'h0, br}, {30'h0, xoc_pkg::RESP_OKAY});
        rdc(xoc_pkg::OFF_STARTUP, 32'h00103FFF);
        wr(xoc_pkg::OFF_STARTUP, 32'h00000001);
        tick_en <= 1'b1;
        wr(xoc_pkg::OFF_CTRL, 32'h00FABAA0);
        wait_set();
        chk(32'(n >= 256 && n < 270), 32'h1);
        rdc(xoc_pkg::OFF_STATUS, 32'h80001000);
        wr(xoc_pkg::OFF_STARTUP, 32'h00100001);
        wr(xoc_pkg::OFF_PAUSE, xoc_pkg::PAUSE_CODE);
        repeat (4) @(posedge clk_sys);
        rdc(xoc_pkg::OFF_STATUS, 32'h00001000);
        chk({31'h0, osc_run}, 32'h0);
        rdc(xoc_pkg::OFF_PAUSE, xoc_pkg::PAUSE_CODE);
        wr(xoc_pkg::OFF_PAUSE, xoc_pkg::RUN_CODE);
        wait_set();
        chk(32'(n >= 1024 && n < 1038), 32'h1);
        $display("test start-up delay done");
        wr(xoc_pkg::OFF_PAUSE, 32'h12345678);
        rdc(xoc_pkg::OFF_PAUSE, xoc_pkg::RUN_CODE);
        rdc(xoc_pkg::OFF_STATUS, 32'h81001000);
        wr(xoc_pkg::OFF_STATUS, 32'h01000000);
        rdc(xoc_pkg::OFF_STATUS, 32'h80001000);
        for (int i = 0; i < 3; i++)
        begin
            wr(xoc_pkg::OFF_CTRL, cw[i]);
            repeat (4) @(posedge clk_sys);
            rdc(xoc_pkg::OFF_STATUS, cs[i]);
            wr(xoc_pkg::OFF_STATUS, 32'h01000000);
        end
        $display("test codes done");
        wr(xoc_pkg::OFF_COUNT, 32'hFFFFFF05);
        rdc(xoc_pkg::OFF_COUNT, 32'h00000005);
        wr(xoc_pkg::OFF_CTRL, 32'h00FABAA0);
        repeat (20) @(posedge clk_sys);
        rdc(xoc_pkg::OFF_COUNT, 32'h0);
        s_axi_wstrb <= 4'h1;
        wr(xoc_pkg::OFF_STARTUP, 32'hFFFFFF22);
        s_axi_wstrb <= 4'hF;
        rdc(xoc_pkg::OFF_STARTUP, 32'h00100022);
        $display("test down counter done");
        complete_run();
    end
endmodule
